/* File: bench/readout_monitor.sv */
// Port assertions for the readout configuration block
`timescale 1ns/1ps
module readout_monitor #(
	parameter int FIFO_DEPTH = 16
) (
	input wire logic        clk_sys,
	input wire logic        nrst,
	input wire logic        cmd_valid,
	input wire logic        cmd_write,
	input wire logic [8:0]  cmd_addr,
	input wire logic [7:0]  cmd_wdata,
	input wire logic [7:0]  rd_data_q,
	input wire logic        rd_valid_q,
	input wire logic [1:0]  input_line_protocol,
	input wire logic        conv_valid,
	input wire logic [17:0] conv_data,
	input wire logic        conv_ready,
	input wire logic        sclk_pin,
	input wire logic        cs_n_pin,
	input wire logic [3:0]  lane_out_q,
	input wire logic [3:0]  lane_oe_n_q,
	input wire logic        sync_clk_out_q
);
	logic [1:0] mode_q; // Protocol field as last written
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!nrst);
	// Shadow of the protocol field, so clock idling can be judged
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst)
			mode_q <= 2'b00;
		else if (cmd_valid && cmd_write && cmd_addr == 9'h018)
			mode_q <= cmd_wdata[1:0];
	end
	// Write then read of one address, two cycles apart
	sequence wr_rd(a);
		(cmd_valid && cmd_write && cmd_addr == a) ##2
		(cmd_valid && !cmd_write && cmd_addr == a);
	endsequence
	// Chip select high long enough to pass the synchroniser
	sequence cs_idle;
		cs_n_pin [*6];
	endsequence
	ctrl_readback_a: assert property (
		wr_rd(9'h018) |=> rd_data_q == ($past(cmd_wdata, 3) & 8'hdf))
		else $error("protocol control readback wrong");
	format_readback_a: assert property (
		wr_rd(9'h01c) |=> rd_data_q == ($past(cmd_wdata, 3) & 8'h3f))
		else $error("word format readback wrong");
	format_reserved_a: assert property (
		rd_valid_q && $past(cmd_addr) == 9'h01c |-> rd_data_q[7:6] == 2'b00)
		else $error("format reserved bits not zero");
	reset_clear_a: assert property (
		$rose(nrst) |-> lane_oe_n_q == 4'hf && !sync_clk_out_q
		&& conv_ready && rd_data_q == 8'h00)
		else $error("outputs not at reset values");
	lane_enable_a: assert property (
		lane_oe_n_q inside {4'hf, 4'he, 4'hc, 4'h0})
		else $error("illegal lane enable pattern");
	idle_lanes_a: assert property (
		cs_idle |-> lane_oe_n_q == 4'hf && lane_out_q == 4'h0)
		else $error("lanes active outside a frame");
	sync_idle_a: assert property (
		cs_idle |-> !sync_clk_out_q)
		else $error("output clock runs outside a frame");
	legacy_clock_a: assert property (
		(mode_q == 2'b00) [*2] |-> !sync_clk_out_q)
		else $error("output clock runs in legacy readout");
endmodule

bind readout_config readout_monitor #(.FIFO_DEPTH(FIFO_DEPTH))
	readout_monitor_inst (
	.clk_sys(clk_sys), .nrst(nrst), .cmd_valid(cmd_valid),
	.cmd_write(cmd_write), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
	.rd_data_q(rd_data_q), .rd_valid_q(rd_valid_q),
	.input_line_protocol(input_line_protocol), .conv_valid(conv_valid),
	.conv_data(conv_data), .conv_ready(conv_ready), .sclk_pin(sclk_pin),
	.cs_n_pin(cs_n_pin), .lane_out_q(lane_out_q),
	.lane_oe_n_q(lane_oe_n_q), .sync_clk_out_q(sync_clk_out_q)
);

/* File: bench/spi_host_model.sv */
// Host controller model: frames chip select and clock, captures lanes
`timescale 1ns/1ps
module spi_host_model (
	input  wire logic       clk_sys,
	input  wire logic [1:0] input_line_protocol,
	input  wire logic [3:0] lane_out_q,
	output logic            sclk_pin,
	output logic            cs_n_pin
);
	localparam int HALF = 8; // Half clock period, well above sync delay
	initial begin
		sclk_pin = 1'b0;
		cs_n_pin = 1'b1;
	end
	// One frame on n lanes; word is captured MSB first
	task automatic frame(input int n, output logic [19:0] word);
		int s;
		int e;
		int i;
		word = '0;
		@(posedge clk_sys);
		sclk_pin <= input_line_protocol[1];
		repeat (HALF) @(posedge clk_sys);
		cs_n_pin <= 1'b0;
		repeat (HALF) @(posedge clk_sys);
		for (s = 0; s < 20 / n; s++) begin
			for (e = 0; e < 2; e++) begin
				// Capture on leading edge for phase 0, trailing for 1
				if (e == int'(input_line_protocol[0]))
					for (i = 0; i < n; i++)
						word = {word[18:0], lane_out_q[i]};
				sclk_pin <= ~sclk_pin;
				repeat (HALF) @(posedge clk_sys);
			end
		end
		cs_n_pin <= 1'b1;
		repeat (HALF) @(posedge clk_sys);
	endtask
endmodule

/* File: bench/tb_readout_config.sv */
// Self-checking bench for the readout configuration block
`timescale 1ns/1ps
module tb_readout_config;
	logic clk_sys = 0, nrst = 0, cmd_valid = 0, cmd_write = 0;
	logic [8:0] cmd_addr = '0;
	logic [7:0] cmd_wdata = '0, rd_data_q;
	logic rd_valid_q, conv_valid = 0, conv_ready, sync_clk_out_q;
	logic [1:0] input_line_protocol = '0;
	logic [17:0] conv_data = '0;
	logic sclk_pin, cs_n_pin, sco_d = 0;
	logic [3:0] lane_out_q, lane_oe_n_q;
	logic [19:0] got, want, sent; // Seen, expected and queued words
	int j; // Bit index for the double-rate expectation
	logic [19:0] q[$]; // Words the model expects out
	int failures = 0, checks = 0, n, k, r, cyc = 0, last = 0, gap = 0;
	always #20 clk_sys = ~clk_sys;
	// Measure the output clock period in system clocks
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		sco_d <= sync_clk_out_q;
		if (sync_clk_out_q && !sco_d) begin
			gap <= cyc - last;
			last <= cyc;
		end
	end
	readout_config readout_config_inst (.clk_sys(clk_sys), .nrst(nrst),
		.cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_addr(cmd_addr),
		.cmd_wdata(cmd_wdata), .rd_data_q(rd_data_q),
		.rd_valid_q(rd_valid_q), .input_line_protocol(input_line_protocol),
		.conv_valid(conv_valid), .conv_data(conv_data),
		.conv_ready(conv_ready), .sclk_pin(sclk_pin), .cs_n_pin(cs_n_pin),
		.lane_out_q(lane_out_q), .lane_oe_n_q(lane_oe_n_q),
		.sync_clk_out_q(sync_clk_out_q));
	spi_host_model spi_host_model_inst (.clk_sys(clk_sys),
		.input_line_protocol(input_line_protocol),
		.lane_out_q(lane_out_q), .sclk_pin(sclk_pin), .cs_n_pin(cs_n_pin));
	task automatic check(input string what, input logic [19:0] seen, exp);
		checks++;
		if (seen !== exp) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic conclude;
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic wr(input logic [8:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		cmd_valid <= 1;
		cmd_write <= 1;
		cmd_addr <= a;
		cmd_wdata <= d;
		@(posedge clk_sys);
		cmd_valid <= 0;
	endtask
	task automatic rd(input logic [8:0] a, input logic [7:0] e);
		@(posedge clk_sys);
		cmd_valid <= 1;
		cmd_write <= 0;
		cmd_addr <= a;
		@(posedge clk_sys);
		cmd_valid <= 0;
		#1;
		check("rd_valid_q", rd_valid_q, 1);
		check("rd_data_q", rd_data_q, e);
	endtask
	// Expected word: body from data or pattern, then two parity bits
	function automatic logic [19:0] model(logic [17:0] d, logic [7:0] f);
		logic [17:0] b;
		b = !f[2] ? d : f[1:0] == 0 ? 18'h00000 : f[1:0] == 1 ? 18'h3ffff
			: f[1:0] == 2 ? 18'h15555 : 18'h03333;
		if (!f[3])
			return {b, 2'b00};
		return {b, ^b, ^(b >> (14 - 4 * f[5:4]))};
	endfunction
	// Offer one word; a stalled handshake ends the run
	task automatic push(input logic [17:0] d, input logic [7:0] f);
		int i;
		@(posedge clk_sys);
		conv_valid <= 1;
		conv_data <= d;
		q.push_back(model(d, f));
		for (i = 0; i < 40 && !conv_ready; i++)
			@(posedge clk_sys);
		@(posedge clk_sys);
		conv_valid <= 0;
		if (i == 40) begin
			failures++;
			conclude();
		end
	endtask
	initial begin
		r = $urandom(52);
		repeat (3) @(posedge clk_sys);
		nrst <= 1;
		rd(9'h018, 8'h00);
		rd(9'h01c, 8'h00);
		rd(9'h010, 8'h00);
		for (k = 0; k < 6; k++) begin
			r = $urandom;
			wr(9'h018, {r[7:6], 1'b0, r[4:2], {2{r[0]}}});
			rd(9'h018, {r[7:6], 1'b0, r[4:2], {2{r[0]}}});
			wr(9'h01c, r[15:8]);
			rd(9'h01c, {2'b00, r[13:8]});
		end
		$display("test registers done");
		for (k = 0; k < 8; k++) begin
			r = $urandom;
			n = k % 4 < 2 ? 1 : k % 4 == 2 ? 2 : 4;
			@(posedge clk_sys);
			input_line_protocol <= 2'(k >> 1);
			wr(9'h018, {3'b000, r[0], 2'(k), 2'b00});
			wr(9'h01c, {2'b00, 2'(k + 1), k[0] ^ k[1], 3'(k)});
			push(r[31:14], {2'b00, 2'(k + 1), k[0] ^ k[1], 3'(k)});
			spi_host_model_inst.frame(n, got);
			check("word", got, q.pop_front());
		end
		$display("test words done");
		wr(9'h018, 8'h0c);
		wr(9'h01c, 8'h3a);
		for (k = 0; k < 16; k++)
			push(18'($urandom), 8'h3a);
		repeat (2) @(posedge clk_sys);
		check("conv_ready", conv_ready, 0);
		for (k = 0; k < 16; k++) begin
			spi_host_model_inst.frame(4, got);
			check("word", got, q.pop_front());
		end
		spi_host_model_inst.frame(4, got);
		check("empty word", got, 0);
		$display("test fifo done");
		for (k = 0; k < 4; k++) begin
			wr(9'h018, {2'(k), 6'b010011});
			spi_host_model_inst.frame(1, got);
			check("clock period", 20'(gap), k == 0 ? 16 : 1 << k);
		end
		$display("test sync clock done");
		// Echo clock with phase-1 framing lines up with host captures
		@(posedge clk_sys);
		input_line_protocol <= 2'b11;
		for (k = 0; k < 2; k++) begin
			wr(9'h018, k == 0 ? 8'h0b : 8'h13);
			push(18'($urandom), 8'h3a);
			spi_host_model_inst.frame(2 - k, got);
			sent = q.pop_front();
			want = sent;
			// Double rate steps on both echo edges, so half the bits pass
			for (j = 0; k == 1 && j < 20; j++)
				want[19 - j] = sent[j < 10 ? 18 - 2 * j : 0];
			check("sync word", got, want);
		end
		$display("test sync data done");
		conclude();
	end
endmodule

/* File: rtl/readout_config.sv */
// Readout protocol and output word configuration with the output path
`include "readout_params.svh"
`timescale 1ns/1ps
module readout_config
	import readout_pkg::*;
#(
	parameter int FIFO_DEPTH = 16
) (
	input  wire logic        clk_sys,
	input  wire logic        nrst,
	input  wire logic        cmd_valid,
	input  wire logic        cmd_write,
	input  wire logic [8:0]  cmd_addr,
	input  wire logic [7:0]  cmd_wdata,
	output logic      [7:0]  rd_data_q,
	output logic             rd_valid_q,
	input  wire logic [1:0]  input_line_protocol,
	input  wire logic        conv_valid,
	input  wire logic [17:0] conv_data,
	output logic             conv_ready,
	input  wire logic        sclk_pin,
	input  wire logic        cs_n_pin,
	output logic      [3:0]  lane_out_q,
	output logic      [3:0]  lane_oe_n_q,
	output logic             sync_clk_out_q
);
	// FIFO depth must suit the word buffer module
	if (FIFO_DEPTH < 2) begin : g_chk
		$error("readout_config: FIFO_DEPTH too small");
	end

	// Even parity of the selected count of most significant body bits
	function automatic logic span_parity(
		input logic [17:0] body,
		input logic [1:0]  span
	);
		logic p;
		p = 1'b0;
		// Body bit 17 is word bit 19, the most significant
		case (span)
			2'b00:   p = ^body[17:14];
			2'b01:   p = ^body[17:10];
			2'b10:   p = ^body[17:6];
			2'b11:   p = ^body[17:2];
			default: p = 1'b0;
		endcase
		return p;
	endfunction

	// Map the top shifter bits onto lanes for the active lane count
	function automatic logic [3:0] lanes_of(
		input logic [19:0] word,
		input logic [1:0]  width
	);
		logic [3:0] l;
		l = 4'h0;
		// Lane 0 always carries the most significant bit in flight
		if (width == 2'b11) begin
			l = {word[16], word[17], word[18], word[19]};
		end else if (width == 2'b10) begin
			l = {2'b00, word[18], word[19]};
		end else begin
			l = {3'b000, word[19]};
		end
		return l;
	endfunction

	// Configuration registers
	logic [7:0] rpc_q;               // Readout protocol control
	logic [7:0] owf_q;               // Output word format

	// Decoded configuration fields
	readout_mode_t readout_protocol_select;
	sync_clk_t     sync_clock_source_select;
	wire [1:0] output_lane_count =
		rpc_q[`RPC_LANES_LSB+1:`RPC_LANES_LSB];
	wire       ddr_select  = rpc_q[`RPC_DDR_BIT];
	wire [2:0] test_pattern_select =
		owf_q[`OWF_PATN_LSB+2:`OWF_PATN_LSB];
	wire       parity_append_enable = owf_q[`OWF_PARITY_APPEND_ENABLE_BIT];
	wire [1:0] partial_parity_span =
		owf_q[`OWF_SPAN_LSB+1:`OWF_SPAN_LSB];

	assign readout_protocol_select =
		readout_mode_t'(rpc_q[`RPC_MODE_LSB+1:`RPC_MODE_LSB]);
	assign sync_clock_source_select =
		sync_clk_t'(rpc_q[`RPC_CLKSEL_LSB+1:`RPC_CLKSEL_LSB]);

	// Register decode
	wire sel_rpc = (cmd_addr == `ADDR_READOUT_CTRL);
	wire sel_owf = (cmd_addr == `ADDR_WORD_FORMAT);
	wire wr_rpc  = cmd_valid & cmd_write & sel_rpc;
	wire wr_owf  = cmd_valid & cmd_write & sel_owf;
	// Any read is answered; unmapped addresses read as zero
	wire rd_req  = cmd_valid & ~cmd_write;

	// Read-only bits come back as stored zeros; unmapped reads give zero
	wire [7:0] rd_mux = sel_rpc ? rpc_q :
		(sel_owf ? owf_q : 8'h00);

	// Register writes; read-only bits are masked off at store time
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			rpc_q <= `RPC_RESET;
			owf_q <= `OWF_RESET;
		end else begin
			if (wr_rpc) begin
				// Bit 5 is held at zero whatever the host sends
				rpc_q <= cmd_wdata & `RPC_WR_MASK;
			end
			if (wr_owf) begin
				// Bits 7:6 are never stored, so they read zero
				owf_q <= cmd_wdata & `OWF_WR_MASK;
			end
		end
	end

	// Read answer, one cycle after the request
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			rd_data_q  <= 8'h00;
			rd_valid_q <= 1'b0;
		end else begin
			// Data holds between reads; valid marks the answer
			rd_valid_q <= rd_req;
			if (rd_req) begin
				rd_data_q <= rd_mux;
			end
		end
	end

	// Output word body: conversion data or a fixed pattern
	logic [17:0] word_body;
	always_comb begin
		// Codes 0xx all pass the converter result through
		case (test_pattern_select)
			3'b100:  word_body = `PATN_ZEROS;
			3'b101:  word_body = `PATN_ONES;
			3'b110:  word_body = `PATN_ALT_BITS;
			3'b111:  word_body = `PATN_ALT_PAIRS;
			default: word_body = conv_data;
		endcase
	end

	// Parity bits, forced low when parity is off
	wire par_full = parity_append_enable & (^word_body);
	wire par_part = parity_append_enable &
		span_parity(word_body, partial_parity_span);
	wire [19:0] word_in = {word_body, par_full, par_part};

	// Word buffer between the converter and the lane shifter
	logic        fifo_out_valid;
	logic [19:0] fifo_out_data;
	logic        fifo_pop;
	logic        fifo_in_ready;

	word_fifo #(
		.WIDTH (`WORD_BITS),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clk_sys   (clk_sys),
		.nrst      (nrst),
		.in_valid  (conv_valid),
		.in_data   (word_in),
		.in_ready  (fifo_in_ready),
		.out_valid (fifo_out_valid),
		.out_data  (fifo_out_data),
		.out_ready (fifo_pop)
	);

	// Ready comes from the FIFO's own room flop
	// A full buffer refuses words; the converter must hold them
	assign conv_ready = fifo_in_ready;

	// Pin synchronisers; first stage feeds only the second
	logic [2:0] sclk_sync_q;         // Stage 3 is the edge history
	logic [2:0] cs_sync_q;
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			sclk_sync_q <= 3'b000;
			cs_sync_q   <= 3'b111;
		end else begin
			sclk_sync_q <= {sclk_sync_q[1:0], sclk_pin};
			cs_sync_q   <= {cs_sync_q[1:0], cs_n_pin};
		end
	end

	// History resets low, so a high idle clock gives one rising edge
	// after reset; the shifter is idle then and ignores it
	wire sclk_rise  = sclk_sync_q[1] & ~sclk_sync_q[2];
	wire sclk_fall  = ~sclk_sync_q[1] & sclk_sync_q[2];
	wire cs_start   = ~cs_sync_q[1] & cs_sync_q[2];
	wire cs_active  = ~cs_sync_q[1];

	// Legacy readout launches on the edge implied by polarity and phase
	wire cpol = input_line_protocol[1];
	wire cpha = input_line_protocol[0];
	wire legacy_launch = (cpol ^ cpha) ? sclk_rise : sclk_fall;

	// Only code 11 selects source-sync; unsupported codes act as legacy
	wire ssync = (readout_protocol_select == RP_SOURCE_SYNC);

	// Divider runs free; its phase against a frame start is arbitrary,
	// so the first output clock half period of a frame may be short
	// Oscillator divider; the system clock stands in for the oscillator
	logic [`DIV_BITS-1:0] div_q;
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			div_q <= '0;
		end else begin
			div_q <= div_q + `DIV_BITS'(1);
		end
	end

	// Half-period tick of the source-synchronous output clock
	logic ss_tick;
	always_comb begin
		case (sync_clock_source_select)
			SC_SCLK_ECHO: ss_tick = sclk_rise | sclk_fall;
			SC_OSC:       ss_tick = 1'b1;
			SC_OSC_DIV2:  ss_tick = div_q[0];
			SC_OSC_DIV4:  ss_tick = (div_q == 2'b11);
			default:      ss_tick = 1'b0;
		endcase
	end

	// Single rate steps on the falling half only; double on each half
	// The edge-rate bit matters only here, in source-sync frames
	wire ss_update = ss_tick & (ddr_select | sync_clk_out_q);

	// Edge-rate bit plays no part in legacy stepping
	logic first_q;                   // Phase-1 first edge holds MSB
	wire legacy_step = legacy_launch & ~(cpha & first_q);
	wire step = ssync ? ss_update : legacy_step;

	// Bits consumed per step for the lane count
	logic [2:0] step_bits;
	assign step_bits = output_lane_count == 2'b11 ? 3'd4 :
		(output_lane_count == 2'b10 ? 3'd2 : 3'd1);

	// Shifter control
	shift_state_t state_q;
	logic [19:0]  shift_q;           // Word being sent, MSB first
	logic [4:0]   left_q;            // Bits still to send
	logic [19:0]  shift_d;
	logic [4:0]   left_d;
	wire          more = (left_q > {2'b00, step_bits});

	// One word leaves per frame; an empty buffer pops nothing
	assign fifo_pop = cs_start & fifo_out_valid;

	// Next shifter contents
	always_comb begin
		shift_d = shift_q;
		left_d  = left_q;
		if (cs_start) begin
			// Empty buffer sends zeros rather than stalling the host
			shift_d = fifo_out_valid ? fifo_out_data : 20'h00000;
			left_d  = 5'd20;
		end else if (state_q == SH_FRAME && step && more) begin
			// Last chunk holds once no full step remains
			shift_d = shift_q << step_bits;
			left_d  = left_q - {2'b00, step_bits};
		end
	end

	// Frame state, shifter and phase flag
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			state_q <= SH_IDLE;
			shift_q <= 20'h00000;
			left_q  <= 5'd0;
			first_q <= 1'b0;
		end else begin
			shift_q <= shift_d;
			left_q  <= left_d;
			case (state_q)
				SH_IDLE: begin
					if (cs_start) begin
						state_q <= SH_FRAME;
						first_q <= 1'b1;
					end
				end
				SH_FRAME: begin
					// A cut frame simply ends; the next one reloads
					if (!cs_active) begin
						state_q <= SH_IDLE;
					end
					if (legacy_launch) begin
						first_q <= 1'b0;
					end
				end
				default: state_q <= SH_IDLE;
			endcase
		end
	end

	// Lane pins and their enables, low while driving
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			lane_out_q  <= 4'h0;
			lane_oe_n_q <= 4'hf;
		end else if (cs_active) begin
			// Next shifter value, so lanes change in the same cycle as the shifter
			lane_out_q  <= lanes_of(shift_d, output_lane_count);
			lane_oe_n_q <= ~lanes_of(20'hfffff, output_lane_count);
		end else begin
			lane_out_q  <= 4'h0;
			lane_oe_n_q <= 4'hf;
		end
	end

	// Output clock toggles per tick inside a source-sync frame
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			sync_clk_out_q <= 1'b0;
		end else if (ssync && state_q == SH_FRAME && cs_active) begin
			// Clock starts low each frame; single rate steps on fall
			if (ss_tick) begin
				sync_clk_out_q <= ~sync_clk_out_q;
			end
		end else begin
			sync_clk_out_q <= 1'b0;
		end
	end
endmodule

/* File: rtl/readout_params.svh */
// Offsets, field positions, reset values and counts for the readout block
`ifndef READOUT_PARAMS_SVH
`define READOUT_PARAMS_SVH

// Register byte addresses on the command port
`define ADDR_READOUT_CTRL   9'h018
`define ADDR_WORD_FORMAT    9'h01c

// Readout protocol control fields
`define RPC_MODE_LSB        0
`define RPC_LANES_LSB       2
`define RPC_DDR_BIT         4
`define RPC_ZERO_BIT        5
`define RPC_CLKSEL_LSB      6
`define RPC_WR_MASK         8'hdf
`define RPC_RESET           8'h00

// Output word format fields
`define OWF_PATN_LSB        0
`define OWF_PARITY_APPEND_ENABLE_BIT      3
`define OWF_SPAN_LSB        4
`define OWF_WR_MASK         8'h3f
`define OWF_RESET           8'h00

// Output word layout and fixed test patterns
`define WORD_BITS           20
`define BODY_BITS           18
`define PATN_ZEROS          18'h00000
`define PATN_ONES           18'h3ffff
`define PATN_ALT_BITS       18'h15555
`define PATN_ALT_PAIRS      18'h03333

// Internal oscillator divider: divide by four needs a two-bit count
`define DIV_BITS            2

`endif

/* File: rtl/readout_pkg.sv */
// Types shared by the readout configuration and output path
package readout_pkg;

	// Readout protocol select codes
	typedef enum logic [1:0] {
		RP_SPI_FOLLOW = 2'b00,
		RP_BAD_01     = 2'b01,
		RP_BAD_10     = 2'b10,
		RP_SOURCE_SYNC = 2'b11
	} readout_mode_t;

	// Source-synchronous clock source codes
	typedef enum logic [1:0] {
		SC_SCLK_ECHO = 2'b00,
		SC_OSC       = 2'b01,
		SC_OSC_DIV2  = 2'b10,
		SC_OSC_DIV4  = 2'b11
	} sync_clk_t;

	// Output shifter states
	typedef enum logic {
		SH_IDLE  = 1'b0,
		SH_FRAME = 1'b1
	} shift_state_t;

endpackage

/* File: rtl/word_fifo.sv */
// Synchronous FIFO holding formatted output words
`timescale 1ns/1ps
module word_fifo #(
	parameter int WIDTH = 20,
	parameter int DEPTH = 16
) (
	input  wire logic             clk_sys,
	input  wire logic             nrst,
	input  wire logic             in_valid,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  in_ready,
	output logic                  out_valid,
	output logic [WIDTH-1:0]      out_data,
	input  wire logic             out_ready
);
	localparam int AW = $clog2(DEPTH);

	// Pointers wrap naturally, so depth must be a power of two
	if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_chk
		$error("word_fifo: DEPTH must be a power of two >= 2");
	end

	logic [WIDTH-1:0] mem [DEPTH];  // Word storage
	logic [AW-1:0]    wr_ptr_q;     // Next slot to fill
	logic [AW-1:0]    rd_ptr_q;     // Oldest word
	logic [AW:0]      count_q;      // Words held
	logic [AW:0]      count_d;
	logic             ready_q;      // Registered room flag
	wire              push = in_valid & ready_q;
	wire              pop  = out_valid & out_ready;

	assign count_d   = count_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
	assign in_ready  = ready_q;
	assign out_valid = (count_q != '0);
	assign out_data  = mem[rd_ptr_q];

	// Storage has no reset; only written slots are ever read
	always_ff @(posedge clk_sys) begin
		if (push) begin
			mem[wr_ptr_q] <= in_data;
		end
	end

	// Pointers, count and room flag
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
			count_q  <= '0;
			ready_q  <= 1'b1;
		end else begin
			wr_ptr_q <= wr_ptr_q + AW'(push);
			rd_ptr_q <= rd_ptr_q + AW'(pop);
			count_q  <= count_d;
			ready_q  <= (count_d != (AW+1)'(DEPTH));
		end
	end
endmodule
